// [vwh_defs.svh]
`ifndef VWH_DEFS_SVH
`define VWH_DEFS_SVH
// ----------------------------------------
// register indices on the indexed port
// ----------------------------------------
`define VWH_IDX_EXT 8'h33
`define VWH_IDX_START 8'h34
`define VWH_IDX_WIDTH 8'h35
// ----------------------------------------
// extension register fields
// ----------------------------------------
`define VWH_EXT_OFS0 7
`define VWH_EXT_START_HI 6:5
`define VWH_EXT_DITHER_OFF 4
`define VWH_EXT_WIDTH_HI 3:2
`define VWH_EXT_BW_IMPROVE 1
`define VWH_EXT_FAST_FIFO 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define VWH_RST_EXT 8'h00
`define VWH_RST_START 8'h00
`define VWH_RST_WIDTH 8'h00
`endif

// [vwh_pkg.sv]
`default_nettype none
package vwh_pkg;
  // ----------------------------------------
  // window fetch position phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    VWH_BEFORE = 2'b00,
    VWH_INSIDE = 2'b01,
    VWH_AFTER = 2'b11
  } vwh_phase_type;
endpackage : vwh_pkg
`default_nettype wire

// [vwh_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module vwh_sync (
  input wire logic clk, // clock
  input wire logic reset_n, // async reset, active low
  input wire logic bypass, // pass raw request straight through
  input wire logic req_in, // raw request
  output logic req_out // request toward the fifo filler
);
  logic s1_q;
  logic s2_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= req_in;
      s2_q <= s1_q;
    end
  end

  assign req_out = bypass ? req_in : s2_q;
endmodule : vwh_sync
`default_nettype wire

// [vwh_ctrl.sv]
`include "vwh_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module vwh_ctrl
  import vwh_pkg::*;
#(
  parameter int POS_W = 10
) (
  input wire logic clk, // 100 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic [7:0] reg_index, // indexed port index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data
  output logic reg_hit, // index belongs to this block
  input wire logic [7:0] offset_high, // surrounding offset upper bits
  input wire logic window_enable, // window active
  input wire logic compressed_fmt, // window shows compressed video
  input wire logic line_start, // start of scanline fetches
  input wire logic surr_fetch, // one surrounding fetch cycle done
  input wire logic win_fetch, // one window fetch cycle done
  input wire logic cpu_req, // cpu wants display memory
  input wire logic fifo_req_raw, // window fifo request from refresh side
  output logic [POS_W-1:0] window_start_column, // assembled start
  output logic [POS_W-1:0] window_span_column, // assembled width
  output logic [8:0] surrounding_offset, // 9-bit surrounding offset
  output logic dither_en, // dither window pixels
  output logic window_refresh, // window fetches in progress
  output logic cpu_grant, // cpu may use display memory
  output logic fifo_req // window fifo request after sync/bypass
);
  logic [7:0] ext_q;
  logic [7:0] start_q;
  logic [7:0] width_q;
  logic [POS_W-1:0] surr_cnt_q;
  logic [POS_W-1:0] win_cnt_q;
  vwh_phase_type phase_q;
  vwh_phase_type phase_d;
  logic [7:0] rdata_d;
  logic wr_ext;
  logic wr_start;
  logic wr_width;
  logic [1:0] start_hi;
  logic [1:0] width_hi;
  logic offset_lsb;
  logic dither_off;
  logic bw_improve;
  logic fast_fifo;
  logic start_reached;
  logic span_reached;
  logic span_empty;
  logic surr_step;
  logic win_step;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // write strobes, one per register
  assign wr_ext = reg_wr && (reg_index == `VWH_IDX_EXT);
  assign wr_start = reg_wr && (reg_index == `VWH_IDX_START);
  assign wr_width = reg_wr && (reg_index == `VWH_IDX_WIDTH);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ext_q <= `VWH_RST_EXT;
    else if (wr_ext)
      ext_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      start_q <= `VWH_RST_START;
    else if (wr_start)
      start_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      width_q <= `VWH_RST_WIDTH;
    else if (wr_width)
      width_q <= reg_wdata;
  end

  always_comb
  begin
    rdata_d = 8'h00;
    case (reg_index)
      `VWH_IDX_EXT: rdata_d = ext_q;
      `VWH_IDX_START: rdata_d = start_q;
      `VWH_IDX_WIDTH: rdata_d = width_q;
      default: rdata_d = 8'h00;
    endcase
  end

  assign reg_hit = (reg_index == `VWH_IDX_EXT) || (reg_index == `VWH_IDX_START)
    || (reg_index == `VWH_IDX_WIDTH);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
  end

  // ----------------------------------------
  // field assembly
  // ----------------------------------------
  assign start_hi = ext_q[`VWH_EXT_START_HI];
  assign width_hi = ext_q[`VWH_EXT_WIDTH_HI];
  assign offset_lsb = ext_q[`VWH_EXT_OFS0];
  assign dither_off = ext_q[`VWH_EXT_DITHER_OFF];
  assign bw_improve = ext_q[`VWH_EXT_BW_IMPROVE];
  assign fast_fifo = ext_q[`VWH_EXT_FAST_FIFO];

  assign window_start_column = POS_W'({start_hi, start_q});
  assign window_span_column = POS_W'({width_hi, width_q});
  assign surrounding_offset = {offset_high, offset_lsb};
  assign dither_en = window_enable && compressed_fmt && !dither_off;

  // ----------------------------------------
  // horizontal window phase tracking
  // ----------------------------------------
  assign start_reached = (surr_cnt_q + POS_W'(1)) == window_start_column;
  assign span_reached = (win_cnt_q + POS_W'(1)) == window_span_column;
  assign span_empty = (window_span_column == '0);
  // start counted in surrounding-depth fetches, width in window-depth fetches
  assign surr_step = (phase_q == VWH_BEFORE) && surr_fetch && window_enable;
  assign win_step = (phase_q == VWH_INSIDE) && win_fetch && window_enable
    && !span_empty;

  always_comb
  begin
    phase_d = phase_q;
    if (line_start)
    begin
      if (window_enable && (window_start_column == '0))
        phase_d = VWH_INSIDE;
      else
        phase_d = VWH_BEFORE;
    end
    else
    begin
      case (phase_q)
        VWH_BEFORE:
        begin
          if (surr_step && start_reached)
            phase_d = VWH_INSIDE;
        end
        VWH_INSIDE:
        begin
          // disabling or a zero width closes the window at once
          if (!window_enable || span_empty)
            phase_d = VWH_AFTER;
          else if (win_step && span_reached)
            phase_d = VWH_AFTER;
        end
        VWH_AFTER: phase_d = VWH_AFTER;
        default: phase_d = VWH_BEFORE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_q <= VWH_BEFORE;
    else
      phase_q <= phase_d;
  end

  // fetch counters restart at every scanline
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      surr_cnt_q <= '0;
    else if (line_start)
      surr_cnt_q <= '0;
    else if (surr_step)
      surr_cnt_q <= surr_cnt_q + POS_W'(1);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      win_cnt_q <= '0;
    else if (line_start)
      win_cnt_q <= '0;
    else if (win_step)
      win_cnt_q <= win_cnt_q + POS_W'(1);
  end

  assign window_refresh = (phase_q == VWH_INSIDE);
  assign cpu_grant = cpu_req && (!window_refresh
    || bw_improve);

  // ----------------------------------------
  // fifo request path
  // ----------------------------------------
  vwh_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .bypass(fast_fifo),
    .req_in(fifo_req_raw),
    .req_out(fifo_req)
  );
endmodule : vwh_ctrl
`default_nettype wire

// [vwh_ctrl_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module vwh_ctrl_chk #(
  parameter int POS_W = 10
) (
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire logic [7:0] reg_index, // index
  input wire logic [7:0] reg_wdata, // data
  input wire logic reg_wr, // write
  input wire logic [7:0] offset_high, // offset top
  input wire logic window_enable, // enable
  input wire logic compressed_fmt, // format
  input wire logic cpu_req, // cpu
  input wire logic fifo_req_raw, // raw req
  input wire logic [POS_W-1:0] window_start_column, // start
  input wire logic [POS_W-1:0] window_span_column, // span
  input wire logic [8:0] surrounding_offset, // offset
  input wire logic dither_en, // dither
  input wire logic window_refresh, // refresh
  input wire logic cpu_grant, // grant
  input wire logic fifo_req // fifo req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic ew;
  assign ew = reg_wr && reg_index == 8'h33;
  a_start_low:
    assert property (reg_wr && reg_index == 8'h34 |=> window_start_column[7:0] == $past(reg_wdata))
      else $error("start low wrong");
  a_start_high:
    assert property (ew |=> window_start_column[9:8] == $past(reg_wdata[6:5])) else $error("start hi");
  a_span_low:
    assert property (reg_wr && reg_index == 8'h35 |=> window_span_column[7:0] == $past(reg_wdata))
      else $error("span low wrong");
  a_span_high:
    assert property (ew |=> window_span_column[9:8] == $past(reg_wdata[3:2])) else $error("span hi");
  a_offset_join:
    assert property (ew |=> surrounding_offset == {offset_high, $past(reg_wdata[7])})
      else $error("offset wrong");
  a_dither_sel:
    assert property (ew |=> dither_en == (window_enable && compressed_fmt && !$past(reg_wdata[4])))
      else $error("dither wrong");
  a_cpu_block:
    assert property (ew ##1 cpu_req |-> cpu_grant == (!window_refresh || $past(reg_wdata[1])))
      else $error("grant wrong");
  a_grant_idle:
    assert property (!cpu_req |-> !cpu_grant) else $error("grant without request");
  a_fifo_bypass:
    assert property (ew && reg_wdata[0] |=> fifo_req == fifo_req_raw) else $error("bypass wrong");
  a_fifo_sync:
    assert property (ew && !reg_wdata[0] ##1 !ew [*2] |-> fifo_req == $past(fifo_req_raw, 2))
      else $error("sync wrong");
endmodule : vwh_ctrl_chk
bind vwh_ctrl vwh_ctrl_chk #(.POS_W(POS_W)) u_chk (.clk, .reset_n, .reg_index, .reg_wdata,
  .reg_wr, .offset_high, .window_enable, .compressed_fmt, .cpu_req, .fifo_req_raw,
  .window_start_column, .window_span_column, .surrounding_offset, .dither_en,
  .window_refresh, .cpu_grant, .fifo_req);
`default_nettype wire

// [vwh_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module vwh_ctrl_tb;
  logic clk, reset_n, reg_wr, reg_rd, window_enable, compressed_fmt, line_start, surr_fetch;
  logic win_fetch, cpu_req, fifo_req_raw, reg_hit, dither_en, window_refresh, cpu_grant, fifo_req;
  logic [7:0] reg_index, reg_wdata, reg_rdata, offset_high;
  logic [9:0] window_start_column, window_span_column;
  logic [8:0] surrounding_offset;
  int error_cnt, total_checks;
  int m [3];
  int exp_in, prev_raw;
  always #5 clk = ~clk;
  vwh_ctrl u_dut (
    .clk(clk),
    .reset_n(reset_n),
    .reg_index(reg_index),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .offset_high(offset_high),
    .window_enable(window_enable),
    .compressed_fmt(compressed_fmt),
    .line_start(line_start),
    .surr_fetch(surr_fetch),
    .win_fetch(win_fetch),
    .cpu_req(cpu_req),
    .fifo_req_raw(fifo_req_raw),
    .window_start_column(window_start_column),
    .window_span_column(window_span_column),
    .surrounding_offset(surrounding_offset),
    .dither_en(dither_en),
    .window_refresh(window_refresh),
    .cpu_grant(cpu_grant),
    .fifo_req(fifo_req)
  );
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_index <= i;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
    if (i inside {8'h33, 8'h34, 8'h35}) m[i - 8'h33] = d;
    #1;
    cmp(window_start_column, {m[0][6:5], m[1][7:0]});
    cmp(window_span_column, {m[0][3:2], m[2][7:0]});
    cmp(surrounding_offset, {offset_high, m[0][7]});
    cmp(dither_en, window_enable & compressed_fmt & !m[0][4]);
    if (m[0][0]) cmp(fifo_req, fifo_req_raw);
  endtask : wr
  task automatic rd(input logic [7:0] i);
    @(posedge clk);
    reg_rd <= 1;
    reg_index <= i;
    @(posedge clk);
    reg_rd <= 0;
    #1;
    cmp(reg_rdata, (i inside {8'h33, 8'h34, 8'h35}) ? m[i - 8'h33][7:0] : 0);
    cmp(reg_hit, 10'(i inside {8'h33, 8'h34, 8'h35}));
  endtask : rd
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    clk = 0;
    reset_n = 0;
    {reg_wr, reg_rd, window_enable, compressed_fmt, line_start, surr_fetch} = '0;
    {win_fetch, cpu_req, fifo_req_raw, reg_index, reg_wdata, offset_high} = '0;
    void'($urandom(80));
    repeat (2) @(posedge clk);
    reset_n <= 1;
    for (int i = 0; i < 4; i++) rd(8'h33 + 8'(i));
    repeat (40)
    begin
      @(posedge clk);
      offset_high <= 8'($urandom);
      {window_enable, compressed_fmt, fifo_req_raw} <= 3'($urandom);
      wr(8'h33 + 8'($urandom_range(3)), 8'($urandom));
      rd(8'h33 + 8'($urandom_range(3)));
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(8'h34, 8'((16 * b) / (32 / 4)));
      wr(8'h35, 8'((4 * 16) / 32));
      wr(8'h33, {6'h00, 1'(b), 1'b0});
      @(posedge clk);
      {window_enable, cpu_req, line_start} <= 3'b111;
      for (int j = 0; j < 2 * b + 4; j++)
      begin
        @(posedge clk);
        if (j == 0) {line_start, surr_fetch, win_fetch} <= 3'b011;
        if (j == 2 * b + 2) {surr_fetch, win_fetch} <= 2'b00;
        exp_in = (j >= 2 * b) && (j < 2 * b + 2);
        #1 cmp(window_refresh, 10'(exp_in));
        cmp(cpu_grant, 10'(!exp_in || b));
      end
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(8'h33, {7'h00, 1'(b)});
      @(posedge clk);
      prev_raw = fifo_req_raw;
      fifo_req_raw <= !fifo_req_raw;
      #1 cmp(fifo_req, 10'(b ? !prev_raw : prev_raw));
      repeat (2) @(posedge clk);
      #1 cmp(fifo_req, 10'(!prev_raw));
    end
    complete_run();
  end
endmodule : vwh_ctrl_tb
`default_nettype wire
